// ### core/mmcs_consts.svh
// constants for the memory and mac clock select block
// What the document says about this block
// (R01) memory interface clock: two sources, one select bit
// (R02) fixed tap is multiplier output divided by 4.5
// (R03) system clock three divider ratio is programmable
// (R04) software keeps memory clock at or below 100 MHz
// (R05) recommended: 600 MHz multiplier, divider three at 3
// (R06) mac bus clock is system clock four
// (R07) mii transmit and receive clocks come from outside
// (R08) rmii reference: external pin or system clock seven
// (R09) select field 0: reference taken from pin
// (R10) select field 8h: clock seven used and driven out
// (R11) internal clock seven misses 50 ppm tolerance
// (R12) source switching is glitch free; code guards only the memory clock, the rmii reference switches directly
// (R13) divider value n divides by n plus one
`ifndef MMCS_CONSTS_SVH
`define MMCS_CONSTS_SVH
`define MMCS_DIV_W 5
`define MMCS_SEL_W 4
`define MMCS_REF_PIN_SEL 4'h0
`define MMCS_REF_INT_SEL 4'h8
`define MMCS_TAP_HALVES 4'h9
`define MMCS_TAP_HIGH 4'h4
`endif

// ### core/mmcs_pkg.sv
// types for the memory and mac clock select block
`include "mmcs_consts.svh"
package mmcs_pkg;
  typedef struct packed {
    logic memif_clock_select_bit;
    logic [`MMCS_DIV_W-1:0] sys_clock_three_divider;
    logic [`MMCS_SEL_W-1:0] rmii_ref_select_field;
    logic rmii_mode;
  } mmcs_cfg_t;
  typedef enum logic [1:0] {
    MMCS_ON_A = 2'b00,
    MMCS_STOP_A = 2'b01,
    MMCS_STOP_B = 2'b11,
    MMCS_ON_B = 2'b10
  } mmcs_sw_t;
endpackage

// ### core/mmcs_glitchless_mux.sv
// glitch free select between two clock-enable streams
`timescale 1ns/1ps
module mmcs_glitchless_mux (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sel,
  input wire logic i_tick_a,
  input wire logic i_tick_b,
  output logic o_tick,
  output logic o_on_b
);
  import mmcs_pkg::*;
  mmcs_sw_t state;
  // two idle cycles (MMCS_STOP_A, MMCS_STOP_B) between sources so no merged or runt pulse escapes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= MMCS_ON_A;
    end else if (i_ce) begin
      case (state)
        MMCS_ON_A: if (i_sel) state <= MMCS_STOP_A; // R12
        MMCS_STOP_A: state <= i_sel ? MMCS_STOP_B : MMCS_ON_A;
        MMCS_STOP_B: state <= i_sel ? MMCS_ON_B : MMCS_STOP_A;
        MMCS_ON_B: if (!i_sel) state <= MMCS_STOP_B; // R12
        default: state <= MMCS_ON_A;
      endcase
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tick <= 1'b0;
      o_on_b <= 1'b0;
    end else if (i_ce) begin
      o_tick <= (state == MMCS_ON_A) ? i_tick_a : ((state == MMCS_ON_B) ? i_tick_b : 1'b0); // R01
      o_on_b <= (state == MMCS_ON_B);
    end
  end
  no_tick_switch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && (state == MMCS_STOP_A || state == MMCS_STOP_B)) |=> !o_tick) // R12
    else $error("tick passed during source switch");
endmodule

// ### core/mmcs_clock_select.sv
// clock source selection for memory interface and ethernet mac
`timescale 1ns/1ps
`include "mmcs_consts.svh"
module mmcs_clock_select #(
  parameter int DIV_W = `MMCS_DIV_W
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_post_tick,
  input wire logic i_mult_tick,
  input wire logic i_sys4_tick,
  input wire logic i_sys7_tick,
  input wire logic i_ref_pin_in,
  input wire mmcs_pkg::mmcs_cfg_t i_cfg,
  output logic o_sys3_tick,
  output logic o_tap_tick,
  output logic o_memif_clock,
  output logic o_memif_on_tap,
  output logic o_mac_bus_clock,
  output logic o_rmii_ref,
  output logic o_ref_pin_out,
  output logic o_ref_pin_oe_n
);
  import mmcs_pkg::*;
  // all *_tick inputs are clock enables on i_mclk; the pin is asynchronous
  logic ref_meta;
  logic ref_sync;
  logic [DIV_W-1:0] div_cnt;
  logic [3:0] tap_cnt;
  logic next_sys3;
  logic mux_tick;
  logic mux_on_b;
  logic ref_int;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
    end else if (i_ce) begin
      ref_meta <= i_ref_pin_in;
      ref_sync <= ref_meta;
    end
  end

  // divider value n gives one output tick every n+1 input ticks
  assign next_sys3 = i_post_tick && (div_cnt >= i_cfg.sys_clock_three_divider); // R13
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div_cnt <= '0;
    end else if (i_ce && i_post_tick) begin
      div_cnt <= next_sys3 ? '0 : div_cnt + 1'b1; // R03
    end
  end

  // 4.5 is done on half periods: nine multiplier edges make one output period
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tap_cnt <= 4'h0;
    end else if (i_ce && i_mult_tick) begin
      tap_cnt <= (tap_cnt == `MMCS_TAP_HALVES - 4'h1) ? 4'h0 : tap_cnt + 4'h1; // R02
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sys3_tick <= 1'b0;
      o_tap_tick <= 1'b0;
    end else if (i_ce) begin
      o_sys3_tick <= next_sys3;
      o_tap_tick <= i_mult_tick && (tap_cnt == `MMCS_TAP_HALVES - 4'h1); // R02
    end
  end

  mmcs_glitchless_mux u_memif_mux (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_sel(i_cfg.memif_clock_select_bit),
    .i_tick_a(o_sys3_tick),
    .i_tick_b(o_tap_tick),
    .o_tick(mux_tick),
    .o_on_b(mux_on_b)
  );

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_memif_clock <= 1'b0;
      o_memif_on_tap <= 1'b0;
      o_mac_bus_clock <= 1'b0;
    end else if (i_ce) begin
      o_memif_clock <= mux_tick; // R01
      o_memif_on_tap <= mux_on_b;
      o_mac_bus_clock <= i_sys4_tick; // R06
    end
  end

  // only the 8h code selects the internal clock; anything else leaves the pin an input
  assign ref_int = i_cfg.rmii_mode && (i_cfg.rmii_ref_select_field == `MMCS_REF_INT_SEL);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rmii_ref <= 1'b0;
      o_ref_pin_out <= 1'b0;
      o_ref_pin_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_rmii_ref <= ref_int ? i_sys7_tick : ref_sync; // R08 R09 R10
      o_ref_pin_out <= ref_int ? i_sys7_tick : 1'b0; // R10
      o_ref_pin_oe_n <= !ref_int; // R09 R10
    end
  end

  sys3_period_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && next_sys3) |=> o_sys3_tick) // R13
    else $error("divided tick missing");
  pin_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && ref_int) |=> !o_ref_pin_oe_n) // R10
    else $error("pin not driven with internal reference");
  pin_input_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_cfg.rmii_ref_select_field == `MMCS_REF_PIN_SEL) |=> o_ref_pin_oe_n) // R09
    else $error("pin driven while external reference chosen");
  ref_source_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && ref_int) |=> (o_rmii_ref == $past(i_sys7_tick))) // R08
    else $error("reference not from clock seven");
  mac_bus_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce |=> (o_mac_bus_clock == $past(i_sys4_tick))) // R06
    else $error("mac bus clock not clock four");
  tap_ratio_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_tap_tick |-> !$past(o_tap_tick)) // R02
    else $error("tap ticks back to back");
  memif_one_src_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_memif_clock && o_memif_on_tap) |-> $past(o_tap_tick, 2)) // R01
    else $error("memory clock not from tap");
  // a frozen block must not invent or drop memory clock pulses
  ce_freeze_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_ce |=> $stable(o_memif_clock)) // R01
    else $error("memory clock moved while frozen");
  mii_pin_input_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && !i_cfg.rmii_mode) |=> o_ref_pin_oe_n) // R09
    else $error("pin driven outside rmii mode");
  sys3_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_post_tick && div_cnt < i_cfg.sys_clock_three_divider) |=> !o_sys3_tick) // R03
    else $error("divided tick early");
endmodule

// ### tb/mmcs_far_model.sv
// far side model: pll ticks and an external phy reference clock on the pin
`timescale 1ns/1ps
module mmcs_far_model (
  input wire logic i_mclk,
  input wire logic i_pin_oe_n,
  input wire logic i_pin_out,
  output logic o_tick,
  output logic o_half,
  output logic o_pin
);
  logic ext_clk = 1'b0;
  always_ff @(posedge i_mclk) begin
    ext_clk <= ~ext_clk;
  end
  assign o_tick = 1'b1;
  assign o_half = ext_clk;
  // a released pin shows the phy clock, a driven one shows the device value
  assign o_pin = i_pin_oe_n ? ext_clk : i_pin_out;
endmodule

// ### tb/mmcs_clock_select_tb.sv
// self-checking bench for the clock select block
`timescale 1ns/1ps
module mmcs_clock_select_tb;
  import mmcs_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic ce = 1'b1;
  logic held;
  mmcs_cfg_t i_cfg = '0;
  logic tick, half, pin, o_sys3_tick, o_tap_tick, o_memif_clock, o_memif_on_tap;
  logic o_mac_bus_clock, o_rmii_ref, o_ref_pin_out, o_ref_pin_oe_n;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int c3, ct, cm, cb, cr;
  initial forever #10 i_mclk = ~i_mclk;
  mmcs_far_model i_far (.i_mclk, .i_pin_oe_n(o_ref_pin_oe_n), .i_pin_out(o_ref_pin_out),
    .o_tick(tick), .o_half(half), .o_pin(pin));
  mmcs_clock_select i_dut (.i_mclk, .i_rst, .i_ce(ce), .i_post_tick(tick),
    .i_mult_tick(tick), .i_sys4_tick(half), .i_sys7_tick(half), .i_ref_pin_in(pin),
    .i_cfg, .o_sys3_tick, .o_tap_tick, .o_memif_clock, .o_memif_on_tap,
    .o_mac_bus_clock, .o_rmii_ref, .o_ref_pin_out, .o_ref_pin_oe_n);
  task automatic stop_test();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input int exp, input int got);
    n_compared++;
    if (exp != got) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  // settle long enough for the mux handover and a whole divider period
  task automatic run(input logic tap, input logic [4:0] div, input logic [3:0] sel, input int n);
    i_cfg <= '{tap, div, sel, 1'b1};
    repeat (20) @(posedge i_mclk);
    {c3, ct, cm, cb, cr} = '0;
    repeat (n) begin
      @(posedge i_mclk);
      c3 += int'(o_sys3_tick);
      ct += int'(o_tap_tick);
      cm += int'(o_memif_clock);
      cb += int'(o_mac_bus_clock);
      cr += int'(o_rmii_ref);
    end
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    int divs[4] = '{0, 2, 3, 4};
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chkb("oe_n after reset", 1'b1, o_ref_pin_oe_n);
    foreach (divs[k]) begin
      run(1'b0, divs[k][4:0], 4'h8, 60);
      chk("sys3 ticks", 60 / (divs[k] + 1), c3);
      chk("memif ticks", 60 / (divs[k] + 1), cm);
      chk("mac bus ticks", 30, cb);
      chk("rmii ref from clock seven", 30, cr);
      chkb("pin driven", 1'b0, o_ref_pin_oe_n);
      chkb("on tap", 1'b0, o_memif_on_tap);
    end
    run(1'b1, 5'h02, 4'h0, 72);
    chk("tap ticks", 8, ct);
    chk("memif on tap", 8, cm);
    chkb("on tap", 1'b1, o_memif_on_tap);
    chkb("pin released", 1'b1, o_ref_pin_oe_n);
    chk("rmii ref from pin", 36, cr);
    i_cfg <= '{1'b0, 5'h00, 4'h8, 1'b0};
    repeat (3) @(posedge i_mclk);
    chkb("pin released outside rmii", 1'b1, o_ref_pin_oe_n);
    ce <= 1'b0;
    repeat (2) @(posedge i_mclk);
    held = o_memif_clock;
    repeat (10) begin
      @(posedge i_mclk);
      chkb("memif frozen", held, o_memif_clock);
    end
    ce <= 1'b1;
    @(posedge i_mclk);
    stop_test();
  end
endmodule
